// >>> fieldbus_master.sv
// partner: fieldbus master issuing explicit get and set requests
`timescale 1ns/100ps
module fieldbus_master
	import teach_pkg::*;
(
	input  wire logic       i_core_clk,
	input  wire logic       i_resp_valid,
	input  wire logic       i_resp_ok,
	input  wire logic [7:0] i_resp_data,
	output logic            o_req_valid = 1'b0,
	output logic            o_req_write = 1'b0,
	output logic [7:0]      o_req_class = 8'h00,
	output logic [7:0]      o_req_instance = TEACH_INSTANCE,
	output logic [7:0]      o_req_attribute = 8'h00,
	output logic [7:0]      o_req_data = 8'h00
);
	// request held up to the taking edge; answer read just after it
	task automatic xfer(input logic w, input logic [7:0] c, i, a, d, output logic ok, output logic [7:0] rd);
		@(posedge i_core_clk);
		o_req_valid <= 1'b1;
		o_req_write <= w;
		o_req_class <= c;
		o_req_instance <= i;
		o_req_attribute <= a;
		o_req_data <= d;
		@(posedge i_core_clk);
		o_req_valid <= 1'b0;
		o_req_data <= ~d; // released data must not keep the last byte
		#1;
		ok = i_resp_valid & i_resp_ok;
		rd = i_resp_data;
	endtask : xfer
endmodule : fieldbus_master

// >>> interval_timer.sv
// file: reloadable down-counter that flags when a programmed interval has elapsed
`timescale 1ns/100ps
module interval_timer
	import teach_pkg::*;
(
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_restart,
	input  wire logic [CNT_W-1:0] i_length,
	output logic                  o_expired
);
	logic [CNT_W-1:0] count;

	// restart loads the length; expiry holds until the next restart
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			count     <= '0;
			o_expired <= 1'b0;
		end
		else if (i_restart)
		begin
			count     <= i_length;
			o_expired <= 1'b0;
		end
		else if (count > 1)
			count <= count - 1'b1;
		else
			o_expired <= 1'b1;
	end
endmodule : interval_timer

// >>> tb_top.sv
// testbench: teach byte, key start, actuator gating and LED sequencing
`timescale 1ns/100ps
module tb_top
	import teach_pkg::*;
;
	localparam int KH = 20;
	localparam logic [3:0] SETS [5] = '{4'b1000, 4'b0000, 4'b0100, 4'b0110, 4'b1101};
	localparam logic [3:0] EXPS [5] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'h2};
	logic       clk = 1'b0, rst_n = 1'b0, key = 1'b0, act_valid = 1'b0, act_value = 1'b0, fin = 1'b0, fault = 1'b0;
	logic       dup_fail = 1'b0, conn = 1'b0, tmo = 1'b0, clash = 1'b0, lost = 1'b0;
	logic       req_valid, req_write, resp_valid, resp_ok, start, busy, act_cmd, s_g, s_r, s_y, b_g, b_r, ok;
	logic [7:0] req_class, req_inst, req_attr, req_data, resp_data, rd;
	int         error_cnt = 0, n_compared = 0, cyc = 0, g, r, y;

	always #12.5 clk = ~clk;

	teach_status #(.KEY_HOLD(KH), .LAMP_STEP(8), .DUP_CHECK(16), .BLINK_HALF(4)) u_teach_status (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_key(key), .i_req_valid(req_valid), .i_req_write(req_write),
		.i_req_class(req_class), .i_req_instance(req_inst), .i_req_attribute(req_attr), .i_req_data(req_data),
		.i_act_valid(act_valid), .i_act_value(act_value), .i_teach_finished(fin), .i_teach_fault(fault),
		.i_dup_fail(dup_fail), .i_dup_clash(clash), .i_bus_lost(lost), .i_master_conn(conn), .i_io_timeout(tmo),
		.o_resp_valid(resp_valid), .o_resp_ok(resp_ok), .o_resp_data(resp_data), .o_teach_start(start),
		.o_teach_busy(busy), .o_act_cmd(act_cmd), .o_stat_green(s_g), .o_stat_red(s_r), .o_stat_yellow(s_y),
		.o_bus_green(b_g), .o_bus_red(b_r));

	fieldbus_master u_fieldbus_master (.i_core_clk(clk), .i_resp_valid(resp_valid), .i_resp_ok(resp_ok),
		.i_resp_data(resp_data), .o_req_valid(req_valid), .o_req_write(req_write), .o_req_class(req_class),
		.o_req_instance(req_inst), .o_req_attribute(req_attr), .o_req_data(req_data));

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// hang guard, ceiling well above the planned run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			error_cnt++;
			$display("[ERR] %0t run too long", $time);
			print_verdict;
		end
	end

	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp)
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		if (got !== exp)
			error_cnt++;
	endtask : cmp

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic bus(input logic w, input logic [7:0] c, a, d);
		u_fieldbus_master.xfer(w, c, TEACH_INSTANCE, a, d, ok, rd);
	endtask : bus

	task automatic act(input logic v);
		@(posedge clk);
		act_valid <= 1'b1;
		act_value <= v;
		@(posedge clk);
		act_valid <= 1'b0;
		act_value <= ~v;
		tick(1);
	endtask : act

	// 0 off, 1 blinking, 2 steady, 3 anything else, over 16 cycles
	function automatic logic [1:0] cls(input int n);
		return (n == 16) ? 2'd2 : (n >= 6 && n <= 10) ? 2'd1 : (n == 0) ? 2'd0 : 2'd3;
	endfunction : cls

	task automatic leds;
		g = 0;
		r = 0;
		y = 0;
		repeat (16)
		begin
			tick(1);
			g += b_g;
			r += b_r;
			y += s_y;
		end
	endtask : leds

	task automatic t_lamps;
		tick(4);
		cmp({5'h0, s_g, s_r, b_g, b_r}, 9'h00A);
		tick(9);
		cmp({5'h0, s_g, s_r, b_g, b_r}, 9'h005);
		tick(9);
		cmp({5'h0, s_g, s_r, b_g, b_r}, 9'h000);
		tick(18);
		cmp({7'h0, b_g, b_r}, 9'h000);
		tick(40);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk);
			{conn, tmo, clash, lost} <= SETS[i];
			tick(3);
			leds;
			cmp({5'h0, cls(g), cls(r)}, {5'h0, EXPS[i]});
		end
		$display("lamps done");
	endtask : t_lamps

	task automatic t_regs;
		logic [7:0] bad [4] = '{8'h01, 8'h02, 8'h03, 8'h80};
		bus(1'b0, TEACH_CLASS, TEACH_ATTRIBUTE, 8'h00);
		cmp({ok, rd}, 9'h101);
		bus(1'b0, TEACH_CLASS, 8'h07, 8'h00);
		cmp({ok, rd}, 9'h000);
		bus(1'b1, 8'h04, TEACH_ATTRIBUTE, 8'h00);
		cmp({ok, 7'h0, start}, 9'h000);
		u_fieldbus_master.xfer(1'b0, TEACH_CLASS, 8'h02, TEACH_ATTRIBUTE, 8'h00, ok, rd);
		cmp({ok, rd}, 9'h000);
		foreach (bad[k])
		begin
			bus(1'b1, TEACH_CLASS, TEACH_ATTRIBUTE, bad[k]);
			cmp({ok, 7'h0, start}, 9'h000);
		end
		$display("regs done");
	endtask : t_regs

	task automatic t_teach;
		act(1'b1);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, TEACH_CLASS, TEACH_ATTRIBUTE, 8'h00);
			cmp({ok, 7'h0, start}, 9'h101);
			tick(1);
			bus(1'b0, TEACH_CLASS, TEACH_ATTRIBUTE, 8'h00);
			// bit 1 still holds the previous outcome while this run is in progress
			cmp({ok, rd}, {1'b1, 6'h0, 1'(i), 1'b0});
			bus(1'b1, TEACH_CLASS, TEACH_ATTRIBUTE, 8'h00);
			cmp({ok, 7'h0, start}, 9'h100);
			act(1'b0);
			cmp({7'h0, busy, act_cmd}, 9'h003);
			leds;
			cmp({7'h0, cls(y)}, 9'h001);
			@(posedge clk);
			fin <= 1'b1;
			fault <= ~i[0];
			@(posedge clk);
			fin <= 1'b0;
			tick(2);
			bus(1'b0, TEACH_CLASS, TEACH_ATTRIBUTE, 8'h00);
			cmp({ok, rd}, {1'b1, 6'h0, fault, 1'b1});
		end
		act(1'b0);
		cmp({8'h0, act_cmd}, 9'h000);
		$display("teach done");
	endtask : t_teach

	task automatic t_key;
		int s;
		for (int n = KH - 4; n <= KH + 4; n += 8)
		begin
			s = 0;
			@(posedge clk);
			key <= 1'b1;
			repeat (n)
			begin
				tick(1);
				s += start;
			end
			@(posedge clk);
			key <= 1'b0;
			fin <= 1'b1;
			@(posedge clk);
			fin <= 1'b0;
			cmp(9'(s), 9'(n > KH));
		end
		$display("key done");
	endtask : t_key

	// address check never completes, so the bus lamp stays dark
	task automatic t_dup_fail;
		@(posedge clk);
		rst_n <= 1'b0;
		dup_fail <= 1'b1;
		{conn, tmo, clash, lost} <= 4'b1000;
		tick(8);
		@(posedge clk);
		rst_n <= 1'b1;
		tick(120);
		leds;
		cmp({5'h0, cls(g), cls(r)}, 9'h000);
		$display("dup fail done");
	endtask : t_dup_fail

	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_lamps;
		t_regs;
		t_teach;
		t_key;
		t_dup_fail;
		print_verdict;
	end
endmodule : tb_top

// >>> teach_pkg.sv
// package: constants and types for the teach and status indication block
package teach_pkg;
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned KEY_HOLD_MS     = 5000;
	localparam int unsigned LAMP_STEP_MS    = 250;
	localparam int unsigned DUP_CHECK_MS    = 2000;
	localparam int unsigned BLINK_HALF_MS   = 500;
	localparam int unsigned KEY_HOLD_CYC    = KEY_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned LAMP_STEP_CYC   = LAMP_STEP_MS * (CLK_HZ / 1000);
	localparam int unsigned DUP_CHECK_CYC   = DUP_CHECK_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam logic [7:0]  TEACH_CLASS     = 8'h96;
	localparam logic [7:0]  TEACH_INSTANCE  = 8'h01;
	localparam logic [7:0]  TEACH_ATTRIBUTE = 8'h08;
	localparam int unsigned BIT_DONE        = 0;
	localparam int unsigned BIT_RESULT      = 1;
	localparam logic [7:0]  TEACH_RESET     = 8'h01;
	localparam int unsigned CNT_W           = 28;
	typedef enum logic [2:0]
	{
		LAMP_GREEN  = 3'b000,
		LAMP_RED    = 3'b001,
		LAMP_OFF    = 3'b010,
		LAMP_FLASH  = 3'b011,
		LAMP_DUP    = 3'b100,
		LAMP_ONLINE = 3'b101
	} lamp_state_type;
endpackage : teach_pkg

// >>> teach_status.sv
// file: teach control byte, key timing, actuator gating and LED sequencing
`timescale 1ns/100ps
module teach_status
	import teach_pkg::*;
#(
	parameter int unsigned KEY_HOLD   = KEY_HOLD_CYC,
	parameter int unsigned LAMP_STEP  = LAMP_STEP_CYC,
	parameter int unsigned DUP_CHECK  = DUP_CHECK_CYC,
	parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
)
(
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_key,
	input  wire logic       i_req_valid,
	input  wire logic       i_req_write,
	input  wire logic [7:0] i_req_class,
	input  wire logic [7:0] i_req_instance,
	input  wire logic [7:0] i_req_attribute,
	input  wire logic [7:0] i_req_data,
	input  wire logic       i_act_valid,
	input  wire logic       i_act_value,
	input  wire logic       i_teach_finished,
	input  wire logic       i_teach_fault,
	input  wire logic       i_dup_fail,
	input  wire logic       i_dup_clash,
	input  wire logic       i_bus_lost,
	input  wire logic       i_master_conn,
	input  wire logic       i_io_timeout,
	output logic            o_resp_valid,
	output logic            o_resp_ok,
	output logic [7:0]      o_resp_data,
	output logic            o_teach_start,
	output logic            o_teach_busy,
	output logic            o_act_cmd,
	output logic            o_stat_green,
	output logic            o_stat_red,
	output logic            o_stat_yellow,
	output logic            o_bus_green,
	output logic            o_bus_red
);
	logic             teach_done;
	logic             teach_result;
	logic [CNT_W-1:0] key_count;
	logic             key_fired;
	logic             start_key;
	logic             start_bus;
	logic [CNT_W-1:0] blink_count;
	logic             blink;
	lamp_state_type   lamp_state;
	lamp_state_type   next_lamp_state;
	logic             step_restart;
	logic [CNT_W-1:0] step_length;
	logic             step_expired;
	logic             seq_armed;

	// the attribute address must match all three fields
	function automatic logic hits_teach(input logic [7:0] c, input logic [7:0] i, input logic [7:0] a);
		hits_teach = (c == TEACH_CLASS) && (i == TEACH_INSTANCE) && (a == TEACH_ATTRIBUTE);
	endfunction : hits_teach

	function automatic logic write_ok(input logic [7:0] d);
		write_ok = (d[BIT_DONE] == 1'b0) && (d[7:BIT_RESULT] == '0);
	endfunction : write_ok

	// key must stay pressed the whole time; release restarts the count
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			key_count <= '0;
			key_fired <= 1'b0;
		end
		else if (!i_key)
		begin
			key_count <= '0;
			key_fired <= 1'b0;
		end
		else if (key_count < CNT_W'(KEY_HOLD - 1))
			key_count <= key_count + 1'b1;
		else
			key_fired <= 1'b1;
	end

	// fires once per press, a held key cannot retrigger
	assign start_key = i_key && !key_fired && (key_count == CNT_W'(KEY_HOLD - 1));
	assign start_bus = i_req_valid && i_req_write && hits_teach(i_req_class, i_req_instance, i_req_attribute)
	                   && write_ok(i_req_data);

	// teach byte: done flag and outcome; a new start clears done
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			teach_done    <= TEACH_RESET[BIT_DONE];
			teach_result  <= TEACH_RESET[BIT_RESULT];
			o_teach_start <= 1'b0;
		end
		else
		begin
			o_teach_start <= 1'b0;
			if (teach_done && (start_key || start_bus))
			begin
				teach_done    <= 1'b0;
				o_teach_start <= 1'b1;
			end
			else if (!teach_done && i_teach_finished)
			begin
				teach_done   <= 1'b1;
				teach_result <= i_teach_fault;
			end
		end
	end

	// explicit message answers, one cycle after the request
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_resp_valid <= 1'b0;
			o_resp_ok    <= 1'b0;
			o_resp_data  <= '0;
		end
		else
		begin
			o_resp_valid <= i_req_valid;
			o_resp_ok    <= 1'b0;
			o_resp_data  <= '0;
			if (i_req_valid && hits_teach(i_req_class, i_req_instance, i_req_attribute))
			begin
				if (!i_req_write)
				begin
					o_resp_ok   <= 1'b1;
					o_resp_data <= {6'h00, teach_result, teach_done};
				end
				else
					o_resp_ok <= write_ok(i_req_data);
			end
		end
	end

	// bus actuator commands are dropped while teach owns the valve
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_act_cmd    <= 1'b0;
			o_teach_busy <= 1'b0;
		end
		else
		begin
			o_teach_busy <= !teach_done;
			if (i_act_valid && teach_done)
				o_act_cmd <= i_act_value;
		end
	end

	// free-running blink, equal halves
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			blink_count <= '0;
			blink       <= 1'b0;
		end
		else if (blink_count >= CNT_W'(BLINK_HALF - 1))
		begin
			blink_count <= '0;
			blink       <= !blink;
		end
		else
			blink_count <= blink_count + 1'b1;
	end

	// self-test step length, picked by the step being left; the LAMP_DUP step after flash takes DUP_CHECK, the others the quarter second
	always_comb
	begin
		step_length = CNT_W'(LAMP_STEP);
		if (lamp_state == LAMP_FLASH)
			step_length = CNT_W'(DUP_CHECK);
	end

	interval_timer u_step
	(
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_restart  (step_restart),
		.i_length   (step_length),
		.o_expired  (step_expired)
	);

	// power-up lamp sequence, then address check, then online
	always_comb
	begin
		next_lamp_state = lamp_state;
		unique case (lamp_state)
			LAMP_GREEN:  if (step_expired) next_lamp_state = LAMP_RED;
			LAMP_RED:    if (step_expired) next_lamp_state = LAMP_OFF;
			LAMP_OFF:    if (step_expired) next_lamp_state = LAMP_FLASH;
			LAMP_FLASH:  if (step_expired) next_lamp_state = LAMP_DUP;
			LAMP_DUP:    if (step_expired && !i_dup_fail) next_lamp_state = LAMP_ONLINE;
			LAMP_ONLINE: next_lamp_state = LAMP_ONLINE;
			default:     next_lamp_state = LAMP_GREEN;
		endcase
	end

	// the timer holds no interval after reset, so the first step is loaded by hand
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			seq_armed <= 1'b0;
		else
			seq_armed <= 1'b1;
	end

	// the expiry flag lags its restart by one cycle, so restart on entry only
	assign step_restart = !seq_armed || (next_lamp_state != lamp_state);

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			lamp_state <= LAMP_GREEN;
		else
			lamp_state <= next_lamp_state;
	end

	// LED drivers, registered
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_stat_green  <= 1'b0;
			o_stat_red    <= 1'b0;
			o_stat_yellow <= 1'b0;
			o_bus_green   <= 1'b0;
			o_bus_red     <= 1'b0;
		end
		else
		begin
			o_stat_yellow <= !teach_done && blink;
			unique case (lamp_state)
				LAMP_GREEN:
				begin
					o_stat_green <= 1'b1;
					o_stat_red   <= 1'b0;
					o_bus_green  <= 1'b1;
					o_bus_red    <= 1'b0;
				end
				LAMP_RED:
				begin
					o_stat_green <= 1'b0;
					o_stat_red   <= 1'b1;
					o_bus_green  <= 1'b0;
					o_bus_red    <= 1'b1;
				end
				LAMP_FLASH:
				begin
					o_stat_green <= !step_expired;
					o_stat_red   <= 1'b0;
					o_bus_green  <= 1'b0;
					o_bus_red    <= 1'b0;
				end
				LAMP_ONLINE:
				begin
					o_stat_green <= 1'b1;
					o_stat_red   <= 1'b0;
					if (i_dup_clash || i_bus_lost)
					begin
						o_bus_green <= 1'b0;
						o_bus_red   <= 1'b1;
					end
					else if (i_io_timeout)
					begin
						o_bus_green <= 1'b0;
						o_bus_red   <= blink;
					end
					else
					begin
						o_bus_green <= i_master_conn || blink;
						o_bus_red   <= 1'b0;
					end
				end
				default:
				begin
					o_stat_green <= (lamp_state == LAMP_DUP);
					o_stat_red   <= 1'b0;
					o_bus_green  <= 1'b0;
					o_bus_red    <= 1'b0;
				end
			endcase
		end
	end
endmodule : teach_status

// >>> teach_status_chk.sv
// checker: port-level assertions for the teach and status block
`timescale 1ns/100ps
module teach_status_chk
	import teach_pkg::*;
(
	input wire logic       i_core_clk,
	input wire logic       i_rst_n,
	input wire logic       i_req_valid,
	input wire logic       i_req_write,
	input wire logic [7:0] i_req_class,
	input wire logic [7:0] i_req_instance,
	input wire logic [7:0] i_req_attribute,
	input wire logic [7:0] i_req_data,
	input wire logic       i_teach_finished,
	input wire logic       o_resp_valid,
	input wire logic       o_resp_ok,
	input wire logic [7:0] o_resp_data,
	input wire logic       o_teach_start,
	input wire logic       o_teach_busy,
	input wire logic       o_act_cmd
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	logic hit;
	// teach byte address decode
	assign hit = i_req_class == TEACH_CLASS && i_req_instance == TEACH_INSTANCE && i_req_attribute == TEACH_ATTRIBUTE;
	// back-to-back starts excluded: the second sees start before it lands
	sequence s_start_req;
		i_req_valid && i_req_write && hit && i_req_data == 8'h00 && !o_teach_busy && !o_teach_start && !$past(i_req_valid);
	endsequence
	sequence s_launch;
		o_teach_start ##1 o_teach_busy;
	endsequence
	sequence s_finish;
		o_teach_busy && i_teach_finished;
	endsequence
	a_resp_follows: assert property (i_req_valid |=> o_resp_valid)
		else $error("no answer");
	a_resp_cause: assert property (o_resp_valid |-> $past(i_req_valid))
		else $error("stray answer");
	a_bit1_refused: assert property (i_req_valid && i_req_write && i_req_data[1] |=> !o_resp_ok)
		else $error("bit1");
	a_bit0_refused: assert property (i_req_valid && i_req_write && i_req_data[0] |=> !o_resp_ok)
		else $error("bit0");
	a_read_format: assert property (i_req_valid && !i_req_write && hit |=> o_resp_ok && o_resp_data[7:2] == 6'h00)
		else $error("read format");
	a_start_launch: assert property (s_start_req |=> s_launch)
		else $error("no launch");
	a_finish_drop: assert property (s_finish |=> ##1 !o_teach_busy)
		else $error("busy stuck");
	a_act_frozen: assert property (o_teach_busy && $past(o_teach_busy) |-> $stable(o_act_cmd))
		else $error("act moved");
endmodule : teach_status_chk
bind teach_status teach_status_chk u_teach_status_chk (.*);
